// >>> rtl/drt_pkg.sv
// drt_pkg: register map, field positions and reset values for the dual
// reload timer block; assumes a plain address/strobe register port.
package drt_pkg;
   // ------------------------------------------------------------------
   // register offsets (word addresses of the plain register port)
   // ------------------------------------------------------------------
   localparam logic [3:0] DRT_OFF_CTRL      = 4'h0;
   localparam logic [3:0] DRT_OFF_CNT       = 4'h1;
   localparam logic [3:0] DRT_OFF_RELCAP_A  = 4'h2;
   localparam logic [3:0] DRT_OFF_RELCAP_B  = 4'h3;
   localparam logic [3:0] DRT_OFF_FASTSEL   = 4'h4;
   localparam logic [3:0] DRT_OFF_PINS      = 4'h5;
   // ------------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------------
   localparam int DRT_BIT_RUN    = 0;
   localparam int DRT_BIT_MODE_L = 1;
   localparam int DRT_BIT_PNDA   = 4;
   localparam int DRT_BIT_ENA    = 5;
   localparam int DRT_BIT_PNDB   = 6;
   localparam int DRT_BIT_ENB    = 7;
   localparam int DRT_BIT_FAST   = 0;
   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]  DRT_CTRL_RST    = 8'h00;
   localparam logic [7:0]  DRT_FASTSEL_RST = 8'h00;
   localparam logic [15:0] DRT_WORD_RST    = 16'h0000;
   // ------------------------------------------------------------------
   // mode encodings of mode bits 3..1
   // ------------------------------------------------------------------
   localparam logic [2:0] DRT_MODE_PWM_TOG = 3'h5;
   localparam logic [2:0] DRT_MODE_PWM     = 3'h4;
   localparam logic [2:0] DRT_MODE_EVT_POS = 3'h0;
   localparam logic [2:0] DRT_MODE_EVT_NEG = 3'h1;
   // reload sequence state
   typedef enum logic [1:0] {
      DRT_SEQ_FIRST = 2'b00,
      DRT_SEQ_NEXTB = 2'b01,
      DRT_SEQ_NEXTA = 2'b11
   } drt_seq_t;
endpackage

// >>> rtl/drt_timer.sv
// drt_timer: one 16-bit down counter with two reload/capture registers,
// pwm, event count and dual-edge capture modes, plus register port.
// assumes pins already synchronous to sys_clk_i; instruction-cycle rate
// given as a one-cycle tick input.
//
// Overview of operation
// - one 16-bit counter plus two 16-bit reload/capture registers
// - pin A is output or input per mode; pin B is input only
// - mode bits 3..1 choose pwm, event count or capture, and edges
// - second instance alone may count at fast clock via fast select bit 0
// - fast select register resets to zero; upper seven bits read zero
// - pwm counts down; first underflow reloads A, then B, A alternately
// - pwm with toggle code flips pin A on every underflow
// - pwm underflows set pending A or B per reload; software clears
// - pwm enables A and B gate interrupts for A and B reloads
// - in pwm and event modes run bit starts and stops counter
// - event mode decrements on chosen edge of pin A
// - event mode underflow sets pending A, interrupts with enable A
// - event mode rising pin B edge sets pending B
// - event mode drives no pwm output on pin A
// - capture mode counts always; pin edges copy count into A or B
// - capture edge polarity chosen separately for pins A and B
// - reading capture registers never disturbs the counter
// - capture events set pending A and B; enables gate their interrupts
// - capture underflow sets run bit as pending, interrupts via enable A
// - control register tolerates any read, write or bit modify
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module drt_timer
   import drt_pkg::*;
#(
   parameter bit FAST_CAPABLE = 1'b1
)(
   // clock, reset, enable
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        inst_tick_i,
   // register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // timer pins
   input  wire logic        timer_pin_a_i,
   input  wire logic        timer_pin_b_i,
   output logic             timer_pin_a_o,
   output logic             timer_pin_a_oe_o,
   // interrupt requests
   output logic             irq_a_o,
   output logic             irq_b_o
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0] count;
   logic [15:0] reload_capture_reg_a;
   logic [15:0] reload_capture_reg_b;
   logic [7:0]  ctrl;
   logic        second_timer_fast_sel;
   logic        pwm_level;
   logic        pin_a_q;
   logic        pin_b_q;
   drt_seq_t    seq;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   wire logic [2:0] mode_sel = ctrl[DRT_BIT_MODE_L +: 3];
   wire logic run_or_underflow_flag = ctrl[DRT_BIT_RUN];
   wire logic pending_flag_a = ctrl[DRT_BIT_PNDA];
   wire logic pending_flag_b = ctrl[DRT_BIT_PNDB];
   wire logic irq_enable_a   = ctrl[DRT_BIT_ENA];
   wire logic irq_enable_b   = ctrl[DRT_BIT_ENB];
   // mode classes
   wire logic is_pwm = (mode_sel == DRT_MODE_PWM_TOG) || (mode_sel == DRT_MODE_PWM);
   wire logic is_evt = (mode_sel == DRT_MODE_EVT_POS) || (mode_sel == DRT_MODE_EVT_NEG);
   wire logic is_cap = !is_pwm && !is_evt;
   // rate tick: fast only for the capable instance with bit 0 set
   wire logic use_fast = FAST_CAPABLE && second_timer_fast_sel;
   wire logic rate_tick = use_fast || inst_tick_i;
   // pin edges, sampled at the active timer rate
   wire logic pin_a_i_now = timer_pin_a_i;
   wire logic rise_a = rate_tick && pin_a_i_now && !pin_a_q;
   wire logic fall_a = rate_tick && !pin_a_i_now && pin_a_q;
   wire logic rise_b = rate_tick && timer_pin_b_i && !pin_b_q;
   wire logic fall_b = rate_tick && !timer_pin_b_i && pin_b_q;
   // capture polarity: bit2 selects pin B falling, bit0 pin A falling
   wire logic cap_a = is_cap && (mode_sel[0] ? fall_a : rise_a);
   wire logic cap_b = is_cap && (mode_sel[2] ? fall_b : rise_b);
   // counting decision
   wire logic evt_edge = mode_sel[0] ? fall_a : rise_a;
   wire logic dec = clk_en_i && (is_cap ? rate_tick :
                    is_pwm ? (rate_tick && run_or_underflow_flag)
                    : (evt_edge && run_or_underflow_flag));
   wire logic underflow = dec && (count == DRT_WORD_RST);
   // reload source: A on first and on A-turn, B on B-turn
   wire logic load_b = is_pwm && (seq == DRT_SEQ_NEXTB);
   wire logic [15:0] reload_val = load_b ? reload_capture_reg_b
                                         : reload_capture_reg_a;
   wire logic [15:0] next_count =
      (underflow && !is_cap) ? reload_val : (dec ? count - 16'h0001 : count);
   // register port strobes
   wire logic wr_ctrl = clk_en_i && reg_wr_i && (reg_addr_i == DRT_OFF_CTRL);
   wire logic wr_cnt  = clk_en_i && reg_wr_i && (reg_addr_i == DRT_OFF_CNT);
   wire logic wr_ra   = clk_en_i && reg_wr_i && (reg_addr_i == DRT_OFF_RELCAP_A);
   wire logic wr_rb   = clk_en_i && reg_wr_i && (reg_addr_i == DRT_OFF_RELCAP_B);
   wire logic wr_fast = clk_en_i && reg_wr_i && (reg_addr_i == DRT_OFF_FASTSEL);
   // hardware set events for each flag
   wire logic set_pnda = (is_pwm && underflow && !load_b)
                      || (is_evt && underflow)
                      || cap_a;
   wire logic set_pndb = (is_pwm && underflow && load_b)
                      || (is_evt && rise_b && clk_en_i)
                      || cap_b;
   wire logic set_run  = is_cap && underflow;
   // control next value: software write, then hardware sets win
   wire logic [7:0] ctrl_base = wr_ctrl ? reg_wdata_i[7:0] : ctrl;
   wire logic [7:0] next_ctrl = ctrl_base
      | ({7'h00, set_run} << DRT_BIT_RUN)
      | ({7'h00, set_pnda && clk_en_i} << DRT_BIT_PNDA)
      | ({7'h00, set_pndb && clk_en_i} << DRT_BIT_PNDB);
   // read mux
   wire logic [15:0] rd_mux =
      (reg_addr_i == DRT_OFF_CTRL)     ? {8'h00, ctrl} :
      (reg_addr_i == DRT_OFF_CNT)      ? count :
      (reg_addr_i == DRT_OFF_RELCAP_A) ? reload_capture_reg_a :
      (reg_addr_i == DRT_OFF_RELCAP_B) ? reload_capture_reg_b :
      (reg_addr_i == DRT_OFF_FASTSEL)  ? {15'h0000, second_timer_fast_sel} :
      (reg_addr_i == DRT_OFF_PINS)     ? {14'h0000, timer_pin_b_i, timer_pin_a_i} :
                                         16'h0000;

   // ------------------------------------------------------------------
   // counter and sequence
   // ------------------------------------------------------------------
   // software write to the counter overrides counting
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count <= DRT_WORD_RST;
      end else if (wr_cnt) begin
         count <= reg_wdata_i;
      end else if (clk_en_i) begin
         count <= next_count;
      end
   end

   // reload alternation; restarts at A whenever pwm is not running
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seq <= DRT_SEQ_FIRST;
      end else if (clk_en_i) begin
         if (!is_pwm || !run_or_underflow_flag) begin
            seq <= DRT_SEQ_FIRST;
         end else if (underflow) begin
            unique case (seq)
               DRT_SEQ_FIRST: seq <= DRT_SEQ_NEXTB;
               DRT_SEQ_NEXTB: seq <= DRT_SEQ_NEXTA;
               DRT_SEQ_NEXTA: seq <= DRT_SEQ_NEXTB;
               default:       seq <= DRT_SEQ_FIRST;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // reload / capture registers
   // ------------------------------------------------------------------
   // reads have no side effect, so capture never disturbs the count
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reload_capture_reg_a <= DRT_WORD_RST;
      end else if (clk_en_i && cap_a) begin
         reload_capture_reg_a <= count;
      end else if (wr_ra) begin
         reload_capture_reg_a <= reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reload_capture_reg_b <= DRT_WORD_RST;
      end else if (clk_en_i && cap_b) begin
         reload_capture_reg_b <= count;
      end else if (wr_rb) begin
         reload_capture_reg_b <= reg_wdata_i;
      end
   end

   // ------------------------------------------------------------------
   // control, fast select, pin sampling
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl <= DRT_CTRL_RST;
      end else if (clk_en_i) begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         second_timer_fast_sel <= DRT_FASTSEL_RST[DRT_BIT_FAST];
      end else if (wr_fast) begin
         second_timer_fast_sel <= reg_wdata_i[DRT_BIT_FAST] && FAST_CAPABLE;
      end
   end

   // previous pin levels, updated at the active timer rate
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_a_q <= 1'b0;
         pin_b_q <= 1'b0;
      end else if (clk_en_i && rate_tick) begin
         pin_a_q <= timer_pin_a_i;
         pin_b_q <= timer_pin_b_i;
      end
   end

   // ------------------------------------------------------------------
   // pwm pin and outputs
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_level <= 1'b0;
      end else if (clk_en_i && underflow && mode_sel == DRT_MODE_PWM_TOG) begin
         pwm_level <= !pwm_level;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer_pin_a_o    <= 1'b0;
         timer_pin_a_oe_o <= 1'b0;
         irq_a_o          <= 1'b0;
         irq_b_o          <= 1'b0;
         reg_rdata_o      <= DRT_WORD_RST;
      end else if (clk_en_i) begin
         timer_pin_a_o    <= pwm_level;
         timer_pin_a_oe_o <= is_pwm;
         // capture mode: run bit acts as underflow pending on line A
         irq_a_o <= irq_enable_a && (pending_flag_a ||
                    (is_cap && run_or_underflow_flag));
         irq_b_o <= irq_enable_b && pending_flag_b;
         reg_rdata_o <= reg_rd_i ? rd_mux : DRT_WORD_RST;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_fast_lock;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !FAST_CAPABLE |-> !second_timer_fast_sel;
   endproperty
   a_fast_lock: assert property (p_fast_lock) else $error("fast select set on slow timer");

   property p_pwm_first_a;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_pwm && underflow && seq == DRT_SEQ_FIRST && !wr_cnt)
         |=> count == $past(reload_capture_reg_a);
   endproperty
   a_pwm_first_a: assert property (p_pwm_first_a) else $error("first reload not from A");

   property p_toggle;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && underflow && mode_sel == DRT_MODE_PWM_TOG) |=> pwm_level != $past(pwm_level);
   endproperty
   a_toggle: assert property (p_toggle) else $error("pwm pin did not toggle");

   property p_pndb_set;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_pwm && underflow && load_b) |=> pending_flag_b;
   endproperty
   a_pndb_set: assert property (p_pndb_set) else $error("pending B not set");

   property p_stop;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && !is_cap && !run_or_underflow_flag && !wr_cnt) |=> $stable(count);
   endproperty
   a_stop: assert property (p_stop) else $error("stopped counter moved");

   property p_cap_a;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && cap_a) |=> reload_capture_reg_a == $past(count) && pending_flag_a;
   endproperty
   a_cap_a: assert property (p_cap_a) else $error("capture A missed");

   property p_cap_uf;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && set_run) |=> run_or_underflow_flag;
   endproperty
   a_cap_uf: assert property (p_cap_uf) else $error("underflow flag not set");

   property p_evt_nopin;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_evt) |=> !timer_pin_a_oe_o;
   endproperty
   a_evt_nopin: assert property (p_evt_nopin) else $error("pin A driven in event mode");

   property p_irq_b;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> irq_b_o == ($past(irq_enable_b) && $past(pending_flag_b));
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("irq B mismatch");

   property p_freeze;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !clk_en_i |=> $stable(count) && $stable(ctrl) && $stable(reload_capture_reg_a);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   property p_pnda_pwm;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_pwm && underflow && !load_b) |=> pending_flag_a;
   endproperty
   a_pnda_pwm: assert property (p_pnda_pwm) else $error("pending A not set");

   property p_evt_uf;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_evt && underflow && !wr_cnt)
         |=> pending_flag_a && count == $past(reload_capture_reg_a);
   endproperty
   a_evt_uf: assert property (p_evt_uf) else $error("event underflow wrong");

   property p_evt_pndb;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_evt && rise_b) |=> pending_flag_b;
   endproperty
   a_evt_pndb: assert property (p_evt_pndb) else $error("pin B edge missed");

   property p_cap_b;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && cap_b) |=> reload_capture_reg_b == $past(count) && pending_flag_b;
   endproperty
   a_cap_b: assert property (p_cap_b) else $error("capture B missed");

   property p_irq_a;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> irq_a_o == ($past(irq_enable_a) &&
         ($past(pending_flag_a) || ($past(is_cap) && $past(run_or_underflow_flag))));
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("irq A mismatch");

   property p_fast_read;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && reg_rd_i && reg_addr_i == DRT_OFF_FASTSEL) |=> reg_rdata_o[15:1] == 15'h0000;
   endproperty
   a_fast_read: assert property (p_fast_read) else $error("fast select upper bits set");

   property p_cap_run;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_cap && rate_tick && !wr_cnt) |=> count == $past(count) - 16'h0001;
   endproperty
   a_cap_run: assert property (p_cap_run) else $error("capture counter stalled");

   property p_pwm_alt_b;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (clk_en_i && is_pwm && underflow && seq == DRT_SEQ_NEXTB && !wr_cnt)
         |=> count == $past(reload_capture_reg_b);
   endproperty
   a_pwm_alt_b: assert property (p_pwm_alt_b) else $error("reload not from B");

   property p_pin_out;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> timer_pin_a_o == $past(pwm_level);
   endproperty
   a_pin_out: assert property (p_pin_out) else $error("pin A level mismatch");
endmodule
`default_nettype wire

// >>> test/drt_pin_model.sv
// drt_pin_model: waveform sources on the two timer pins, load on pin A.
// assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
`default_nettype none
module drt_pin_model (
   // clock
   input  wire logic sys_clk_i,
   // timer side of pin A
   input  wire logic drv_a_i,
   input  wire logic oe_a_i,
   // pin levels
   output logic      pin_a_o,
   output logic      pin_b_o
);
   logic src_a;
   // pin A shows the timer's level while it drives, else the source
   assign pin_a_o = oe_a_i ? drv_a_i : src_a;
   initial begin
      src_a = 1'b0;
      pin_b_o = 1'b0;
   end
   // set idle levels and let them settle
   task automatic idle(input logic a, input logic b);
      @(posedge sys_clk_i);
      src_a <= a;
      pin_b_o <= b;
      repeat (5) @(posedge sys_clk_i);
   endtask
   // flip chosen sources and hold long enough for a slow tick
   task automatic edge_ab(input logic on_a, input logic on_b);
      @(posedge sys_clk_i);
      src_a <= src_a ^ on_a;
      pin_b_o <= pin_b_o ^ on_b;
      repeat (6) @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// >>> test/dual_reload_timer_pwm_capture_tb_top.sv
// bench for drt_timer: register tasks, pin model, interval model queue.
// assumes the second instance (fast capable) and a 1-in-4 rate tick.
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timer_pwm_capture_tb_top;
   import drt_pkg::*;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, d, v, v2, ra, rb;
   logic        pin_a, pin_b, drv_a, oe_a, irq_a, irq_b, last_a = 1'b0;
   logic [1:0]  div = 2'h0;
   logic [2:0]  cm[4] = '{3'h2, 3'h3, 3'h6, 3'h7};
   int failures = 0, comparisons = 0, cyc = 0, gap = 0, q[$], e[$];
   // ------------------------------------------------------------------
   // clock, rate tick, timeout
   // ------------------------------------------------------------------
   always #12.5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      div <= div + 2'h1;
      tick <= (div == 2'h3);
      cyc++;
      if (cyc == 30000) begin
         failures++;
         wrap_up();
      end
   end
   // interval model: cycles between pin A toggles while driven
   always @(posedge sys_clk_i) begin
      gap++;
      if (oe_a === 1'b1 && drv_a !== last_a) begin
         q.push_back(gap);
         gap = 0;
      end
      last_a <= drv_a;
   end
   drt_timer #(.FAST_CAPABLE(1'b1)) dut_u (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
      .inst_tick_i(tick), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .timer_pin_a_i(pin_a), .timer_pin_b_i(pin_b), .timer_pin_a_o(drv_a),
      .timer_pin_a_oe_o(oe_a), .irq_a_o(irq_a), .irq_b_o(irq_b));
   drt_pin_model mdl (.sys_clk_i(sys_clk_i), .drv_a_i(drv_a), .oe_a_i(oe_a),
      .pin_a_o(pin_a), .pin_b_o(pin_b));
   // ------------------------------------------------------------------
   // register port and checking tasks
   // ------------------------------------------------------------------
   task automatic wreg(input logic [3:0] a, input logic [15:0] x);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [15:0] x);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 x = rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse_a();
      mdl.edge_ab(1'b1, 1'b0);
      mdl.edge_ab(1'b1, 1'b0);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      d = $urandom(3024);
      repeat (4) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      // reset values of fast select and control, unmapped place
      rreg(DRT_OFF_FASTSEL, d); chk(d, 16'h0000);
      rreg(DRT_OFF_CTRL, d); chk(d, 16'h0000);
      wreg(4'h6, 16'hffff); rreg(4'h6, d); chk(d, 16'h0000);
      $display("test reset done");
      // capture mode counts at tick rate, then at fast rate; reads harmless
      wreg(DRT_OFF_CTRL, 16'h0004);
      rreg(DRT_OFF_CNT, v); rreg(DRT_OFF_RELCAP_A, d); rreg(DRT_OFF_CNT, v2);
      chk(v - v2, 16'h0001);
      wreg(DRT_OFF_FASTSEL, 16'hffff); rreg(DRT_OFF_FASTSEL, d); chk(d, 16'h0001);
      rreg(DRT_OFF_CNT, v); rreg(DRT_OFF_RELCAP_B, d); rreg(DRT_OFF_CNT, v2);
      chk(v - v2, 16'h0004);
      // clock enable low for eight edges: only three decrements remain
      rreg(DRT_OFF_CNT, v);
      @(posedge sys_clk_i);
      en <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      en <= 1'b1;
      rreg(DRT_OFF_CNT, v2); chk(v - v2, 16'h0003);
      $display("test rate done");
      // each capture edge choice: right edge sets flags, wrong edge not
      foreach (cm[i]) begin
         wreg(DRT_OFF_CTRL, 16'h0000);
         mdl.idle(cm[i][0], cm[i][2]);
         wreg(DRT_OFF_CTRL, {8'h00, 4'ha, cm[i], 1'b0});
         mdl.edge_ab(1'b1, 1'b1);
         rreg(DRT_OFF_CTRL, d); chk(d & 16'h0050, 16'h0050);
         chk({14'h0, irq_a, irq_b}, 16'h0003);
         wreg(DRT_OFF_CTRL, {8'h00, 4'h0, cm[i], 1'b0});
         mdl.edge_ab(1'b1, 1'b1);
         rreg(DRT_OFF_CTRL, d); chk(d & 16'h0050, 16'h0000);
      end
      // captured value lies just above the count read afterwards
      wreg(DRT_OFF_CTRL, 16'h0000);
      mdl.idle(1'b0, 1'b0);
      wreg(DRT_OFF_CNT, 16'h8000); wreg(DRT_OFF_CTRL, 16'h0004);
      mdl.edge_ab(1'b1, 1'b0);
      rreg(DRT_OFF_CNT, v); rreg(DRT_OFF_RELCAP_A, d);
      v2 = d - v;
      chk({15'h0, (v2 > 16'h0 && v2 < 16'h0010)}, 16'h0001);
      // underflow in capture sets the run bit and interrupt A
      wreg(DRT_OFF_CTRL, 16'h0000); wreg(DRT_OFF_CNT, 16'h0003);
      wreg(DRT_OFF_CTRL, 16'h0024);
      repeat (10) @(posedge sys_clk_i);
      rreg(DRT_OFF_CTRL, d); chk(d & 16'h0011, 16'h0001);
      chk({15'h0, irq_a}, 16'h0001);
      $display("test capture done");
      // pwm with toggle and both enables, then no toggle with enable A only
      for (int t = 1; t >= 0; t--) begin
         ra = 16'h2 + 16'($urandom % 10);
         rb = 16'h2 + 16'($urandom % 10);
         wreg(DRT_OFF_CTRL, 16'h0000);
         wreg(DRT_OFF_RELCAP_A, ra); wreg(DRT_OFF_RELCAP_B, rb);
         wreg(DRT_OFF_CNT, 16'h0002);
         q.delete();
         e = '{int'(ra) + 1, int'(rb) + 1, int'(ra) + 1, int'(rb) + 1};
         wreg(DRT_OFF_CTRL, (t == 1) ? 16'h00ab : 16'h0029);
         repeat (3 * (ra + rb) + 30) @(posedge sys_clk_i);
         chk({15'h0, oe_a}, 16'h0001);
         rreg(DRT_OFF_CTRL, d); chk(d & 16'h0050, 16'h0050);
         chk({14'h0, irq_a, irq_b}, {14'h0, 1'b1, t == 1});
         if (t == 1) begin
            foreach (e[i]) chk(16'(q[i + 1]), 16'(e[i]));
         end else begin
            chk(16'(q.size()), 16'h0000);
         end
      end
      wreg(DRT_OFF_CTRL, 16'h0000);
      repeat (4) @(posedge sys_clk_i);
      rreg(DRT_OFF_CNT, v); repeat (8) @(posedge sys_clk_i); rreg(DRT_OFF_CNT, v2);
      chk(v2, v);
      $display("test pwm done");
      // event counting on rising pin A edges, reload from A, pin B flag
      mdl.idle(1'b0, 1'b0);
      wreg(DRT_OFF_RELCAP_A, 16'h0002); wreg(DRT_OFF_CNT, 16'h0001);
      wreg(DRT_OFF_CTRL, 16'h00a1);
      pulse_a(); rreg(DRT_OFF_CTRL, d); chk(d & 16'h0010, 16'h0000);
      pulse_a(); rreg(DRT_OFF_CTRL, d); chk(d & 16'h0010, 16'h0010);
      chk({14'h0, irq_a, oe_a}, 16'h0002);
      wreg(DRT_OFF_CTRL, 16'h00a1);
      pulse_a(); pulse_a(); rreg(DRT_OFF_CTRL, d); chk(d & 16'h0010, 16'h0000);
      pulse_a(); rreg(DRT_OFF_CTRL, d); chk(d & 16'h0010, 16'h0010);
      mdl.edge_ab(1'b0, 1'b1);
      rreg(DRT_OFF_CTRL, d); chk(d & 16'h0040, 16'h0040);
      chk({15'h0, irq_b}, 16'h0001);
      $display("test event done");
      wrap_up();
   end
endmodule
`default_nettype wire
